// >>> dv/tb_post_reset_clock_setup.sv
// self-checking bench for the post-reset clock setup block
`timescale 1ns/10ps
module tb_post_reset_clock_setup
	import clk_setup_pkg::*;
;
	logic       clk;
	logic       sys_rst;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] rdata;
	logic       sub_osc_on;
	logic       main_osc_on;
	logic       pll_on;
	logic       fast_osc_on;
	logic [2:0] active_source;
	logic [3:0] core_clock_divide_field;
	logic       memory_wait_enabled;
	logic       dma_run;
	logic       xfer_run;
	logic       ram_run;
	logic       battery_backup_on;
	logic [7:0] absent_port_dir;
	logic       wait_violation;
	logic [7:0] rd_val;
	logic [7:0] run_bits;
	int         fails;
	int         n_tests;

	// short waits keep the main and sub stabilisation within a few cycles
	post_reset_clock_setup #(.MAIN_WAIT(4), .SUB_WAIT(4)) uut (
		.clk                            (clk),
		.sys_rst                        (sys_rst),
		.addr                           (addr),
		.wdata                          (wdata),
		.wr_en                          (wr_en),
		.rd_en                          (rd_en),
		.rdata                          (rdata),
		.sub_osc_on                     (sub_osc_on),
		.main_osc_on                    (main_osc_on),
		.pll_on                         (pll_on),
		.fast_osc_on                    (fast_osc_on),
		.active_source                  (active_source),
		.core_clock_divide_field        (core_clock_divide_field),
		.memory_wait_enabled            (memory_wait_enabled),
		.direct_transfer_controller_run (dma_run),
		.data_transfer_controller_run   (xfer_run),
		.onchip_ram_block_run           (ram_run),
		.battery_backup_on              (battery_backup_on),
		.absent_port_dir                (absent_port_dir),
		.wait_violation                 (wait_violation)
	);

	// run outputs packed for one compare
	assign run_bits = {5'h00, dma_run, xfer_run, ram_run};

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic results();
		$display("tests %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string msg);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// one-cycle write; returns just after the sampling edge has settled
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	// bounded poll of the source in use
	task automatic wait_src(input logic [2:0] exp, input int bound);
		int i;
		for (i = 0; i < bound && active_source !== exp; i++) begin
			@(posedge clk);
			#1;
		end
		chk({5'h00, active_source}, {5'h00, exp}, "source switch");
		if (active_source !== exp) begin
			results();
		end
	endtask : wait_src

	initial begin
		logic [2:0] order [5];
		sys_rst = 1'b1;
		addr    = 4'h0;
		wdata   = 8'h00;
		wr_en   = 1'b0;
		rd_en   = 1'b0;
		fails   = 0;
		n_tests = 0;
		order   = '{SRC_SUB, SRC_MAIN, SRC_PLL, SRC_FAST, SRC_LOCO};
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		// reset state
		chk(run_bits, 8'h07, "run at reset");
		chk({7'h00, battery_backup_on}, 8'h01, "backup at reset");
		chk({7'h00, sub_osc_on}, 8'h01, "sub at reset");
		chk({5'h00, active_source}, {5'h00, SRC_LOCO}, "source at reset");
		chk({4'h0, core_clock_divide_field}, {4'h0, RST_DIVIDE}, "divide");
		chk(absent_port_dir, RST_PORT_DIR, "port dir at reset");
		$display("test reset done");
		// dma stopped first, then xfer and ram together, backup switched off, port dir
		wr(ADDR_MODULE_STOP, 8'h01);
		chk(run_bits, 8'h03, "stop dma");
		wr(ADDR_MODULE_STOP, 8'h07);
		chk(run_bits, 8'h00, "stop all");
		wr(ADDR_BACKUP, 8'h01);
		chk({7'h00, battery_backup_on}, 8'h00, "backup off");
		wr(ADDR_PORT_DIR, 8'hA5);
		chk(absent_port_dir, 8'hA5, "port dir out");
		rd(ADDR_PORT_DIR, rd_val);
		chk(rd_val, 8'hA5, "port dir read");
		rd(4'hF, rd_val);
		chk(rd_val, 8'h00, "unmapped read");
		$display("test peripherals done");
		// a switch to a stopped source must not happen
		wr(ADDR_CLK_SOURCE, {5'h00, SRC_FAST});
		repeat (20) @(posedge clk);
		#1;
		chk({5'h00, active_source}, {5'h00, SRC_LOCO}, "held");
		// sub clock: each control bit keeps it alive on its own
		wr(ADDR_SUB_OSC_CTRL, 8'h01);
		chk({7'h00, sub_osc_on}, 8'h00, "sub stopped");
		wr(ADDR_RTC_CTRL3, 8'h01);
		chk({7'h00, sub_osc_on}, 8'h01, "rtc keeps sub");
		wr(ADDR_SUB_OSC_CTRL, 8'h00);
		wr(ADDR_RTC_CTRL3, 8'h00);
		chk({7'h00, sub_osc_on}, 8'h01, "stop bit clear");
		// bring-up order: main, pll, fast; pending fast select then lands
		wr(ADDR_OSC_ENABLE, 8'h01);
		chk({7'h00, main_osc_on}, 8'h01, "main on");
		repeat (8) @(posedge clk);
		wr(ADDR_OSC_ENABLE, 8'h03);
		chk({7'h00, pll_on}, 8'h01, "pll on");
		wr(ADDR_OSC_ENABLE, 8'h07);
		chk({7'h00, fast_osc_on}, 8'h01, "fast on");
		chk({5'h00, active_source}, {5'h00, SRC_LOCO}, "old");
		wait_src(SRC_FAST, 2400);
		repeat (2100) @(posedge clk);
		rd(ADDR_STATUS, rd_val);
		chk({4'h0, rd_val[3:0]}, 8'h0F, "all ready");
		$display("test bring-up done");
		// every source code, sub kept running while selected
		foreach (order[i]) begin
			wr(ADDR_CLK_SOURCE, {5'h00, order[i]});
			wait_src(order[i], 10);
			chk({7'h00, sub_osc_on}, 8'h01, "sub kept");
		end
		// divide-by-1 on pll without waits is flagged
		wr(ADDR_CLK_SOURCE, {5'h00, SRC_PLL});
		wait_src(SRC_PLL, 10);
		wr(ADDR_CLK_DIVIDER, {4'h0, DIVIDE_BY_1});
		chk({4'h0, core_clock_divide_field}, 8'h00, "divide by 1");
		chk({7'h00, wait_violation}, 8'h01, "pll no wait");
		rd(ADDR_MEM_WAIT, rd_val);
		chk({6'h00, rd_val[1:0]}, 8'h02, "flag read");
		wr(ADDR_MEM_WAIT, 8'h01);
		chk({6'h00, memory_wait_enabled, wait_violation}, 8'h02,
			"waits on");
		// 32 MHz is not above the ceiling
		wr(ADDR_MEM_WAIT, 8'h00);
		wr(ADDR_CLK_SOURCE, {5'h00, SRC_FAST});
		wait_src(SRC_FAST, 10);
		chk({7'h00, wait_violation}, 8'h00, "fast no wait");
		// a code that no oscillator answers to is never taken
		wr(ADDR_CLK_SOURCE, 8'h05);
		repeat (10) @(posedge clk);
		rd(ADDR_CLK_SOURCE, rd_val);
		chk(rd_val, {2'h0, SRC_FAST, 3'h5}, "bad code");
		$display("test sources done");
		// second reset in mid-run puts run bits, backup, sub, source and port dir back
		wr(ADDR_SUB_OSC_CTRL, 8'h01);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk(run_bits, 8'h07, "run after reset");
		chk({7'h00, battery_backup_on}, 8'h01, "backup again");
		chk({7'h00, sub_osc_on}, 8'h01, "sub again");
		chk({5'h00, active_source}, {5'h00, SRC_LOCO}, "source again");
		chk(absent_port_dir, RST_PORT_DIR, "port dir again");
		$display("test second reset done");
		results();
	end
endmodule : tb_post_reset_clock_setup

// >>> logic/clk_setup_pkg.sv
// constants, register map and types for the post-reset clock setup block
// Operation
// - transfer controllers and on-chip ram run from reset; software stops them
// - battery backup is active from power-on with no software action
// - sub oscillator runs if stop bit clear or rtc enable bit set
// - sub oscillator runs at power-on; software must stop it explicitly
package clk_setup_pkg;
	// register indices (byte address = index * 4 is not used; plain port)
	localparam logic [3:0] ADDR_SUB_OSC_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_RTC_CTRL3      = 4'h1;
	localparam logic [3:0] ADDR_OSC_ENABLE     = 4'h2;
	localparam logic [3:0] ADDR_CLK_DIVIDER    = 4'h3;
	localparam logic [3:0] ADDR_CLK_SOURCE     = 4'h4;
	localparam logic [3:0] ADDR_MEM_WAIT       = 4'h5;
	localparam logic [3:0] ADDR_MODULE_STOP    = 4'h6;
	localparam logic [3:0] ADDR_BACKUP         = 4'h7;
	localparam logic [3:0] ADDR_PORT_DIR       = 4'h8;
	localparam logic [3:0] ADDR_STATUS         = 4'h9;
	// field positions
	localparam int BIT_SUB_STOP   = 0;
	localparam int BIT_RTC_EN     = 0;
	localparam int BIT_MAIN_EN    = 0;
	localparam int BIT_PLL_EN     = 1;
	localparam int BIT_FAST_EN    = 2;
	localparam int BIT_WAIT_EN    = 0;
	localparam int BIT_STOP_DMA   = 0;
	localparam int BIT_STOP_XFER  = 1;
	localparam int BIT_STOP_RAM   = 2;
	localparam int BIT_BACKUP_OFF = 0;
	// reset values
	localparam logic [7:0]  RST_PORT_DIR = 8'h00;
	localparam logic [3:0]  RST_DIVIDE   = 4'h2;
	localparam logic [3:0]  DIVIDE_BY_1  = 4'h0;
	// source codes for the clock source select field
	localparam logic [2:0] SRC_LOCO = 3'h0;
	localparam logic [2:0] SRC_FAST = 3'h1;
	localparam logic [2:0] SRC_MAIN = 3'h2;
	localparam logic [2:0] SRC_SUB  = 3'h3;
	localparam logic [2:0] SRC_PLL  = 3'h4;
	// source frequencies in kHz and the wait-free ceiling
	localparam int FAST_KHZ       = 32000;
	localparam int MAIN_KHZ       = 8000;
	localparam int PLL_KHZ        = 54000;
	localparam int NO_WAIT_MAX_KHZ = 32000;
	// stabilisation times and their cycle counts at 40 MHz
	localparam int CLK_MHZ      = 40;
	localparam int PLL_WAIT_US  = 50;
	localparam int FAST_WAIT_US = 56;
	localparam int MAIN_WAIT_US = 4200;
	localparam int SUB_WAIT_MS  = 1300;
	localparam int PLL_CYCLES   = PLL_WAIT_US * CLK_MHZ;
	localparam int FAST_CYCLES  = FAST_WAIT_US * CLK_MHZ;
	localparam int MAIN_CYCLES  = MAIN_WAIT_US * CLK_MHZ;
	localparam int SUB_CYCLES   = SUB_WAIT_MS * 1000 * CLK_MHZ;
	localparam int CNT_W        = 26;
	typedef enum logic [2:0] {
		SW_IDLE  = 3'b001,
		SW_CHECK = 3'b010,
		SW_APPLY = 3'b100
	} switch_state_t;
endpackage : clk_setup_pkg

// >>> logic/osc_link_if.sv
// interface carrying one oscillator's enable and ready between modules
`timescale 1ns/10ps
interface osc_link_if;
	logic enable;
	logic ready;
	modport ctrl (output enable, input ready);
	modport osc  (input enable, output ready);
endinterface : osc_link_if

// >>> logic/osc_stable_timer.sv
// stabilisation timer for one oscillator enable
`timescale 1ns/10ps
module osc_stable_timer
	import clk_setup_pkg::*;
#(
	parameter int WAIT_CYCLES = 4
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	osc_link_if.osc   link
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(WAIT_CYCLES - 1);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             done;
	logic             next_done;

	// count while enabled, restart when stopped
	always_comb begin
		next_count = count;
		next_done  = done;
		if (!link.enable) begin
			next_count = '0;
			next_done  = 1'b0;
		end else if (!done) begin
			if (count == LAST)
				next_done = 1'b1;
			else
				next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end

	assign link.ready = done & link.enable;

	a_ready_needs_count: assert property (
		@(posedge clk) disable iff (sys_rst)
		$rose(link.ready) |-> $past(count) == LAST)
		else $error("oscillator ready before its wait ran out");
endmodule : osc_stable_timer

// >>> logic/post_reset_clock_setup.sv
// post-reset clock setup: oscillator control, source switch, reset states
`timescale 1ns/10ps
module post_reset_clock_setup
	import clk_setup_pkg::*;
#(
	parameter int MAIN_WAIT = MAIN_CYCLES,
	parameter int SUB_WAIT  = SUB_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	output logic            sub_osc_on,
	output logic            main_osc_on,
	output logic            pll_on,
	output logic            fast_osc_on,
	output logic      [2:0] active_source,
	output logic      [3:0] core_clock_divide_field,
	output logic            memory_wait_enabled,
	output logic            direct_transfer_controller_run,
	output logic            data_transfer_controller_run,
	output logic            onchip_ram_block_run,
	output logic            battery_backup_on,
	output logic      [7:0] absent_port_dir,
	output logic            wait_violation
);
	// software-visible control bits
	logic       sub_osc_stop_bit;
	logic       rtc_osc_enable_bit;
	logic [2:0] osc_en;
	logic [2:0] clock_source_select_field;
	logic       wait_bit;
	logic [2:0] mstop;
	logic       backup_off;
	logic [7:0] port_dir;
	logic [3:0] divide;
	// next values, one per control bit
	logic       next_sub_stop;
	logic       next_rtc_en;
	logic [2:0] next_osc_en;
	logic [2:0] next_sel;
	logic       next_wait;
	logic [2:0] next_mstop;
	logic       next_backup_off;
	logic [7:0] next_port_dir;
	logic [3:0] next_divide;
	logic [7:0] next_rdata;

	// one enable and ready pair per oscillator
	osc_link_if sub_link ();
	osc_link_if main_link ();
	osc_link_if pll_link ();
	osc_link_if fast_link ();

	// sub runs when either owner wants it; at reset stop bit is clear
	assign sub_link.enable  = !sub_osc_stop_bit | rtc_osc_enable_bit;
	assign main_link.enable = osc_en[BIT_MAIN_EN];
	// pll has the main oscillator as its reference
	assign pll_link.enable  = osc_en[BIT_PLL_EN] & main_link.ready;
	assign fast_link.enable = osc_en[BIT_FAST_EN];

	// crystal waits depend on the board, so main and sub are parameters
	osc_stable_timer #(.WAIT_CYCLES(SUB_WAIT)) u_sub (
		.clk     (clk),
		.sys_rst (sys_rst),
		.link    (sub_link)
	);
	osc_stable_timer #(.WAIT_CYCLES(MAIN_WAIT)) u_main (
		.clk     (clk),
		.sys_rst (sys_rst),
		.link    (main_link)
	);
	osc_stable_timer #(.WAIT_CYCLES(PLL_CYCLES)) u_pll (
		.clk     (clk),
		.sys_rst (sys_rst),
		.link    (pll_link)
	);
	osc_stable_timer #(.WAIT_CYCLES(FAST_CYCLES)) u_fast (
		.clk     (clk),
		.sys_rst (sys_rst),
		.link    (fast_link)
	);

	// register writes and read data
	always_comb begin
		next_sub_stop   = sub_osc_stop_bit;
		next_rtc_en     = rtc_osc_enable_bit;
		next_osc_en     = osc_en;
		next_sel        = clock_source_select_field;
		next_wait       = wait_bit;
		next_mstop      = mstop;
		next_backup_off = backup_off;
		next_port_dir   = port_dir;
		next_divide     = divide;
		next_rdata      = 8'h00;
		if (wr_en) begin
			if (addr == ADDR_SUB_OSC_CTRL) begin
				next_sub_stop = wdata[BIT_SUB_STOP];
			end else if (addr == ADDR_RTC_CTRL3) begin
				next_rtc_en = wdata[BIT_RTC_EN];
			end else if (addr == ADDR_OSC_ENABLE) begin
				next_osc_en = wdata[2:0];
			end else if (addr == ADDR_CLK_DIVIDER) begin
				next_divide = wdata[3:0];
			end else if (addr == ADDR_CLK_SOURCE) begin
				next_sel = wdata[2:0];
			end else if (addr == ADDR_MEM_WAIT) begin
				next_wait = wdata[BIT_WAIT_EN];
			end else if (addr == ADDR_MODULE_STOP) begin
				next_mstop = wdata[2:0];
			end else if (addr == ADDR_BACKUP) begin
				next_backup_off = wdata[BIT_BACKUP_OFF];
			end else if (addr == ADDR_PORT_DIR) begin
				next_port_dir = wdata;
			end
		end
		if (rd_en) begin
			if (addr == ADDR_SUB_OSC_CTRL) begin
				next_rdata = {7'h00, sub_osc_stop_bit};
			end else if (addr == ADDR_RTC_CTRL3) begin
				next_rdata = {7'h00, rtc_osc_enable_bit};
			end else if (addr == ADDR_OSC_ENABLE) begin
				next_rdata = {5'h00, osc_en};
			end else if (addr == ADDR_CLK_DIVIDER) begin
				next_rdata = {4'h0, divide};
			end else if (addr == ADDR_CLK_SOURCE) begin
				next_rdata = {2'h0, active_source, clock_source_select_field};
			end else if (addr == ADDR_MEM_WAIT) begin
				next_rdata = {6'h00, wait_violation, wait_bit};
			end else if (addr == ADDR_MODULE_STOP) begin
				next_rdata = {5'h00, mstop};
			end else if (addr == ADDR_BACKUP) begin
				next_rdata = {7'h00, backup_off};
			end else if (addr == ADDR_PORT_DIR) begin
				next_rdata = port_dir;
			end else if (addr == ADDR_STATUS) begin
				next_rdata = {4'h0, fast_link.ready, pll_link.ready,
					main_link.ready, sub_link.ready};
			end
		end
	end

	// module stops and backup-off come up zero so those blocks run from reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sub_osc_stop_bit          <= 1'b0;
			rtc_osc_enable_bit        <= 1'b0;
			osc_en                    <= 3'h0;
			clock_source_select_field <= SRC_LOCO;
			wait_bit                  <= 1'b0;
			mstop                     <= 3'h0;
			backup_off                <= 1'b0;
			port_dir                  <= RST_PORT_DIR;
			divide                    <= RST_DIVIDE;
			rdata                     <= 8'h00;
		end else begin
			sub_osc_stop_bit          <= next_sub_stop;
			rtc_osc_enable_bit        <= next_rtc_en;
			osc_en                    <= next_osc_en;
			clock_source_select_field <= next_sel;
			wait_bit                  <= next_wait;
			mstop                     <= next_mstop;
			backup_off                <= next_backup_off;
			port_dir                  <= next_port_dir;
			divide                    <= next_divide;
			rdata                     <= next_rdata;
		end
	end

	// readiness of the requested source
	logic sel_ready;
	always_comb begin
		case (clock_source_select_field)
			SRC_LOCO: sel_ready = 1'b1;
			SRC_FAST: sel_ready = fast_link.ready;
			SRC_MAIN: sel_ready = main_link.ready;
			SRC_SUB:  sel_ready = sub_link.ready;
			SRC_PLL:  sel_ready = pll_link.ready;
			default:  sel_ready = 1'b0;
		endcase
	end

	// source switch fsm: only a stable source is taken over
	switch_state_t state;
	switch_state_t next_state;
	logic [2:0]    next_active;
	always_comb begin
		next_state  = state;
		next_active = active_source;
		case (state)
			SW_IDLE: begin
				if (clock_source_select_field != active_source)
					next_state = SW_CHECK;
			end
			SW_CHECK: begin
				if (clock_source_select_field == active_source)
					next_state = SW_IDLE;
				else if (sel_ready)
					next_state = SW_APPLY;
			end
			SW_APPLY: begin
				// a select rewritten during the check is tested again
				if (sel_ready)
					next_active = clock_source_select_field;
				next_state  = SW_IDLE;
			end
			default: next_state = SW_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state         <= SW_IDLE;
			active_source <= SRC_LOCO;
		end else begin
			state         <= next_state;
			active_source <= next_active;
		end
	end

	// frequencies are build-time constants, so this is a fixed map
	// pll source at divide-by-1 without wait is flagged for software
	logic over_limit;
	always_comb begin
		case (active_source)
			SRC_FAST: over_limit = FAST_KHZ > NO_WAIT_MAX_KHZ;
			SRC_MAIN: over_limit = MAIN_KHZ > NO_WAIT_MAX_KHZ;
			SRC_PLL:  over_limit = PLL_KHZ > NO_WAIT_MAX_KHZ;
			default:  over_limit = 1'b0;
		endcase
	end
	// flag only: inserting waits stays a software decision
	assign wait_violation = (divide == DIVIDE_BY_1) & over_limit & !wait_bit;

	// outputs toward the rest of the chip
	assign sub_osc_on                     = sub_link.enable;
	assign main_osc_on                    = main_link.enable;
	assign pll_on                         = pll_link.enable;
	assign fast_osc_on                    = fast_link.enable;
	assign core_clock_divide_field        = divide;
	assign memory_wait_enabled            = wait_bit;
	assign direct_transfer_controller_run = !mstop[BIT_STOP_DMA];
	assign data_transfer_controller_run   = !mstop[BIT_STOP_XFER];
	assign onchip_ram_block_run           = !mstop[BIT_STOP_RAM];
	assign battery_backup_on              = !backup_off;
	assign absent_port_dir                = port_dir;

	// switch safety, reset states and flags
	sequence s_apply;
		state == SW_APPLY;
	endsequence

	sequence s_check_unready;
		state == SW_CHECK && !sel_ready;
	endsequence

	a_switch_when_ready: assert property (
		@(posedge clk) disable iff (sys_rst)
		$changed(active_source) |-> $past(state) == SW_APPLY)
		else $error("source changed without the apply step");
	a_apply_needs_ready: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_apply |-> $past(sel_ready))
		else $error("apply taken for an unstable source");
	a_new_source_ready: assert property (
		@(posedge clk) disable iff (sys_rst)
		$changed(active_source) |-> $past(sel_ready))
		else $error("switched to a source that was not ready");
	a_hold_unready: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_check_unready |=> $stable(active_source))
		else $error("source changed while the target was unstable");
	a_sub_by_two_bits: assert property (
		@(posedge clk) disable iff (sys_rst)
		sub_osc_on == (!sub_osc_stop_bit || rtc_osc_enable_bit))
		else $error("sub oscillator ignores its control bits");
	a_sub_runs_at_reset: assert property (
		@(posedge clk)
		$fell(sys_rst) |-> sub_osc_on)
		else $error("sub oscillator not running after reset");
	a_blocks_run_reset: assert property (
		@(posedge clk)
		$fell(sys_rst) |-> direct_transfer_controller_run
			&& data_transfer_controller_run && onchip_ram_block_run)
		else $error("transfer blocks stopped after reset");
	a_backup_at_reset: assert property (
		@(posedge clk)
		$fell(sys_rst) |-> battery_backup_on)
		else $error("battery backup off after reset");
	a_wait_flag_pll: assert property (
		@(posedge clk) disable iff (sys_rst)
		(active_source == SRC_PLL && divide == DIVIDE_BY_1 && !wait_bit)
			|-> wait_violation)
		else $error("missing wait violation flag");
	a_wait_flag_fast: assert property (
		@(posedge clk) disable iff (sys_rst)
		(active_source == SRC_FAST) |-> !wait_violation)
		else $error("fast source flagged at the ceiling");
	a_port_dir_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wr_en && addr == ADDR_PORT_DIR) |=> absent_port_dir == $past(wdata))
		else $error("port direction write lost");
endmodule : post_reset_clock_setup
